// [include/rbs_pkg.sv]
// What this block does
// - exactly three registers in this bank
// - break wait flag shows break ended wait
// - writing zero clears break wait flag
// - bus reset clears break wait flag
// - reading reset status returns then clears
// - power-on sets its flag, clears others
// - other resets set only their own flag
// - external line reset sets its flag
// - watchdog timeout sets its flag
// - illegal opcode sets its flag
// - only illegal opcode fetch address sets flag
// - undervoltage reset sets its flag
// - clear enable bit gates clears in break
// - flag cleared in break stays cleared
// - two-step clears stay protected during break
package rbs_pkg;
	// byte offsets of the three registers
	localparam logic [3:0] off_break_wait_status = 4'h0;
	localparam logic [3:0] off_reset_source_status = 4'h4;
	localparam logic [3:0] off_break_flag_clear_control = 4'h8;
	// bit positions
	localparam int pos_break_wait_flag = 1;
	localparam int pos_break_flag_clear_enable = 7;
	localparam int pos_undervoltage = 1;
	localparam int pos_bad_fetch = 3;
	localparam int pos_bad_opcode = 4;
	localparam int pos_watchdog = 5;
	localparam int pos_pin = 6;
	localparam int pos_power_on = 7;
	// reset values
	localparam logic [7:0] rst_reset_source_status = 8'h80;
	localparam logic rst_break_flag_clear_enable = 1'b0;
	// axi responses
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	// reset cause pulses from the reset controller
	typedef struct packed {
		logic power_on;
		logic pin;
		logic watchdog;
		logic bad_opcode;
		logic bad_fetch;
		logic undervoltage;
	} reset_cause_s;
endpackage : rbs_pkg

// [src/reset_break_status_regs.sv]
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module reset_break_status_regs (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [3:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	// axi4-lite write data
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	// axi4-lite write response
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	// axi4-lite read address
	input wire logic [3:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	// axi4-lite read data
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// system events, same clock
	input wire rbs_pkg::reset_cause_s reset_cause,
	input wire logic break_wait_exit,
	input wire logic break_active,
	// to other modules: status clears permitted
	output logic flag_clear_allowed
);
	// held write address and data, either may arrive first
	logic aw_held;
	logic w_held;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic w_lane0;
	logic ar_held;
	logic [3:0] ar_addr;
	// register contents
	logic break_wait_flag;
	logic [7:0] reset_source_status;
	logic break_flag_clear_enable;
	// strobes
	logic wr_go;
	logic rd_go;

	assign s_awready = !aw_held && !s_bvalid;
	assign s_wready = !w_held && !s_bvalid;
	assign s_arready = !ar_held && !s_rvalid;
	// commit when both halves present
	assign wr_go = aw_held && w_held && !s_bvalid;
	assign rd_go = ar_held && !s_rvalid;
	// clears are blocked in break unless enabled
	assign flag_clear_allowed = !break_active || break_flag_clear_enable;

	// decode a byte address to a mapped register
	function automatic logic mapped(input logic [3:0] a);
		mapped = (a == rbs_pkg::off_break_wait_status) ||
			(a == rbs_pkg::off_reset_source_status) ||
			(a == rbs_pkg::off_break_flag_clear_control);
	endfunction : mapped

	// write channel capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0;
			w_lane0 <= 1'b0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_awaddr;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				w_held <= 1'b1;
				w_data <= s_wdata;
				w_lane0 <= s_wstrb[0];
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_bvalid <= 1'b0;
			s_bresp <= rbs_pkg::resp_okay;
		end else if (wr_go) begin
			s_bvalid <= 1'b1;
			s_bresp <= mapped(aw_addr) ? rbs_pkg::resp_okay : rbs_pkg::resp_slverr;
		end else if (s_bready) begin
			s_bvalid <= 1'b0;
		end
	end

	// read address capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_held <= 1'b0;
			ar_addr <= 4'h0;
		end else if (s_arvalid && s_arready) begin
			ar_held <= 1'b1;
			ar_addr <= s_araddr;
		end else if (rd_go) begin
			ar_held <= 1'b0;
		end
	end

	// read data, upper bits always zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0;
			s_rresp <= rbs_pkg::resp_okay;
		end else if (rd_go) begin
			s_rvalid <= 1'b1;
			s_rresp <= mapped(ar_addr) ? rbs_pkg::resp_okay : rbs_pkg::resp_slverr;
			unique case (ar_addr)
				rbs_pkg::off_break_wait_status: begin
					s_rdata <= {30'h0, break_wait_flag, 1'b0};
				end
				rbs_pkg::off_reset_source_status: begin
					s_rdata <= {24'h0, reset_source_status[7:3], 1'b0,
						reset_source_status[1], 1'b0};
				end
				rbs_pkg::off_break_flag_clear_control: begin
					s_rdata <= {24'h0, break_flag_clear_enable, 7'h0};
				end
				default: begin
					s_rdata <= 32'h0;
				end
			endcase
		end else if (s_rready) begin
			s_rvalid <= 1'b0;
		end
	end

	// break wait flag: set beats clear, reset clears
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			break_wait_flag <= 1'b0;
		end else if (break_wait_exit) begin
			break_wait_flag <= 1'b1;
		end else if (wr_go && w_lane0 && aw_addr == rbs_pkg::off_break_wait_status &&
			!w_data[rbs_pkg::pos_break_wait_flag] && flag_clear_allowed) begin
			break_wait_flag <= 1'b0;
		end
	end

	// reset source flags; they survive the bus reset, only power-on inits them
	always_ff @(posedge aclk) begin
		if (reset_cause.power_on) begin
			reset_source_status <= rbs_pkg::rst_reset_source_status;
		end else begin
			// read clears unless protected by break; new causes win
			if (rd_go && ar_addr == rbs_pkg::off_reset_source_status && flag_clear_allowed) begin
				reset_source_status <= 8'h0;
			end
			if (reset_cause.pin) begin
				reset_source_status[rbs_pkg::pos_pin] <= 1'b1;
			end
			if (reset_cause.watchdog) begin
				reset_source_status[rbs_pkg::pos_watchdog] <= 1'b1;
			end
			if (reset_cause.bad_opcode) begin
				reset_source_status[rbs_pkg::pos_bad_opcode] <= 1'b1;
			end
			if (reset_cause.bad_fetch) begin
				reset_source_status[rbs_pkg::pos_bad_fetch] <= 1'b1;
			end
			if (reset_cause.undervoltage) begin
				reset_source_status[rbs_pkg::pos_undervoltage] <= 1'b1;
			end
		end
	end

	// clear enable control bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			break_flag_clear_enable <= rbs_pkg::rst_break_flag_clear_enable;
		end else if (wr_go && w_lane0 && aw_addr == rbs_pkg::off_break_flag_clear_control) begin
			break_flag_clear_enable <= w_data[rbs_pkg::pos_break_flag_clear_enable];
		end
	end
endmodule : reset_break_status_regs

// [tb/rbs_sva.sv]
`timescale 1ns/1ps
module rbs_sva (
	// clock, reset
	input wire logic aclk, aresetn,
	// bus handshakes
	input wire logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready,
	input wire logic s_arvalid, s_arready, s_rvalid, s_rready,
	input wire logic [3:0] s_araddr,
	input wire logic [1:0] s_bresp, s_rresp,
	input wire logic [31:0] s_rdata,
	// break side
	input wire logic break_active, flag_clear_allowed
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_wr; s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:2] s_bvalid; endproperty
	a_wr: assert property (p_wr) else $error("write not answered");
	property p_rd; s_arvalid && s_arready |-> ##[1:2] s_rvalid; endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_bh; s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp); endproperty
	a_bh: assert property (p_bh) else $error("write response dropped");
	property p_rh; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata); endproperty
	a_rh: assert property (p_rh) else $error("read data dropped");
	property p_hi; s_rvalid |-> s_rdata[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper bits not zero");
	// unmapped offset answers with an error and zero data
	property p_um;
		s_arvalid && s_arready && s_araddr == 4'hc |-> ##[1:2]
			s_rvalid && s_rresp == rbs_pkg::resp_slverr && s_rdata == 32'h0;
	endproperty
	a_um: assert property (p_um) else $error("unmapped read answered wrong");
	property p_fa; !break_active |-> flag_clear_allowed; endproperty
	a_fa: assert property (p_fa) else $error("clears blocked outside break");
	property p_bv; s_bvalid && s_bready |=> !s_bvalid; endproperty
	a_bv: assert property (p_bv) else $error("second write response");
	c_wr: cover property (s_bvalid && s_bready);
	c_rd: cover property (s_rvalid && s_rready);
	c_blk: cover property (break_active && !flag_clear_allowed);
endmodule : rbs_sva
bind reset_break_status_regs rbs_sva rbs_sva_inst (.*);

// [tb/tb_top.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
	// bus and event drivers
	logic aclk = 0, aresetn = 0, s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
	logic s_rready = 0, break_wait_exit = 0, break_active = 0;
	logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'h1;
	logic [31:0] s_wdata = 32'h0, s_rdata, got;
	rbs_pkg::reset_cause_s reset_cause = '0;
	logic s_awready, s_wready, s_bvalid, s_rvalid, s_arready, flag_clear_allowed;
	logic [1:0] s_bresp, s_rresp, gresp;
	int n_fail = 0, compares = 0;
	reset_break_status_regs reset_break_status_regs_inst (.*);
	always #20 aclk = ~aclk;
	task end_sim;
		$display("fails %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_sim
	// one bus cycle; readies are looked at mid-cycle, valids released on the next edge
	task xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
		logic da, dw;
		int i;
		da = 0;
		dw = !w;
		if (w) begin
			s_awaddr <= a; s_wdata <= d; s_awvalid <= 1'b1; s_wvalid <= 1'b1;
		end else begin
			s_araddr <= a; s_arvalid <= 1'b1;
		end
		for (i = 0; i < 20 && !(da && dw); i++) begin
			@(negedge aclk);
			da |= w ? s_awready : s_arready;
			dw |= w & s_wready;
			@(posedge aclk);
			if (da) begin s_awvalid <= 1'b0; s_arvalid <= 1'b0; end
			if (dw) s_wvalid <= 1'b0;
		end
		for (; i < 40 && !(w ? s_bvalid : s_rvalid); i++) @(negedge aclk);
		if (i >= 40) begin n_fail++; end_sim; end
		got = s_rdata;
		gresp = w ? s_bresp : s_rresp;
		// ready raised late on purpose, so the slave must hold its answer
		@(posedge aclk); s_bready <= w; s_rready <= !w;
		@(posedge aclk); s_bready <= 1'b0; s_rready <= 1'b0;
	endtask : xfer
	task rd(input logic [3:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		`CHK("rdata", e, got)
	endtask : rd
	task pl(input rbs_pkg::reset_cause_s c, input logic b);
		reset_cause <= c; break_wait_exit <= b;
		@(posedge aclk); reset_cause <= '0; break_wait_exit <= 1'b0;
		@(posedge aclk);
	endtask : pl
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		pl(6'h20, 1'b0); rd(4'h4, 32'h80);
		rd(4'h4, 32'h0);
		pl(6'h10, 1'b0); pl(6'h07, 1'b0); rd(4'h4, 32'h5a);
		pl(6'h08, 1'b0); rd(4'h4, 32'h20);
		pl(6'h10, 1'b0); pl(6'h20, 1'b0); rd(4'h4, 32'h80);
		rd(4'h0, 32'h0); pl(6'h00, 1'b1); rd(4'h0, 32'h2);
		xfer(1'b1, 4'h0, 32'h0); `CHK("bresp", rbs_pkg::resp_okay, gresp)
		rd(4'h0, 32'h0);
		xfer(1'b1, 4'hc, 32'hffffffff); `CHK("bresp", rbs_pkg::resp_slverr, gresp)
		rd(4'h8, 32'h0); xfer(1'b1, 4'h8, 32'hffffffff); rd(4'h8, 32'h80);
		// in break with clears disabled, nothing may be lost
		xfer(1'b1, 4'h8, 32'h0); break_active <= 1'b1; pl(6'h10, 1'b1);
		`CHK("allowed", 1'b0, flag_clear_allowed)
		rd(4'h4, 32'h40); rd(4'h4, 32'h40); xfer(1'b1, 4'h0, 32'h0); rd(4'h0, 32'h2);
		xfer(1'b1, 4'h8, 32'h80); rd(4'h4, 32'h40); xfer(1'b1, 4'h0, 32'h0);
		break_active <= 1'b0; rd(4'h4, 32'h0); rd(4'h0, 32'h0);
		rd(4'hc, 32'h0); `CHK("rresp", rbs_pkg::resp_slverr, gresp)
		pl(6'h00, 1'b1); aresetn <= 1'b0; @(posedge aclk); aresetn <= 1'b1; @(posedge aclk);
		rd(4'h0, 32'h0);
		rd(4'h8, 32'h0);
		end_sim;
	end
endmodule : tb_top
